// >>> bench/tb_top.sv
// Self-checking bench for the switch core host port and serial path
`timescale 1ns/1ps
module tb_top;
  logic REF_CLK, SRST, CLK_EN, SER_CLK, FRAME_PULSE_IN, RESET_N, CS_N;
  logic STROBE_OR_READ_IN, RW_OR_WR_IN, ADDRESS_LATCH_STROBE, BUS_STYLE_SELECT, RW_STROBE_STYLE;
  logic [7:0] SERIAL_IN_STREAMS, SERIAL_OUT_STREAMS, SERIAL_OUT_OE, HOST_ADDRESS_LINES;
  logic [7:0] MUXED_ADDR_DATA_LOW_IN, MUXED_ADDR_DATA_LOW_OUT, DATA_HIGH_BYTE_IN;
  logic [7:0] DATA_HIGH_BYTE_OUT;
  logic MUXED_ADDR_DATA_LOW_OE, DATA_HIGH_BYTE_OE, TRANSFER_ACK_N, TRANSFER_ACK_OE;
  logic [15:0] r;
  int fail_count, tests_run;

  tsi_switch u_tsi_switch (.REF_CLK, .SRST, .CLK_EN, .SER_CLK, .FRAME_PULSE_IN,
    .SERIAL_IN_STREAMS, .SERIAL_OUT_STREAMS, .SERIAL_OUT_OE, .RESET_N, .CS_N,
    .STROBE_OR_READ_IN, .RW_OR_WR_IN, .ADDRESS_LATCH_STROBE, .BUS_STYLE_SELECT,
    .RW_STROBE_STYLE, .HOST_ADDRESS_LINES, .MUXED_ADDR_DATA_LOW_IN, .MUXED_ADDR_DATA_LOW_OUT,
    .MUXED_ADDR_DATA_LOW_OE, .DATA_HIGH_BYTE_IN, .DATA_HIGH_BYTE_OUT, .DATA_HIGH_BYTE_OE,
    .TRANSFER_ACK_N, .TRANSFER_ACK_OE);

  tsi_far_model u_tsi_far_model (.SER_CLK, .FRAME_PULSE_IN, .SERIAL_IN_STREAMS);

  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic tick;
    @(posedge REF_CLK);
    #2;
  endtask

  // Idle strobe level depends on the bus style
  task automatic bus_idle;
    CS_N = 1'b1;
    ADDRESS_LATCH_STROBE = 1'b0;
    STROBE_OR_READ_IN = (BUS_STYLE_SELECT && !RW_STROBE_STYLE) ? 1'b0 : 1'b1;
    RW_OR_WR_IN = 1'b1;
  endtask

  task automatic host(input logic mux, input logic rdwr, input logic rd, input logic [7:0] a,
      input logic [15:0] wd, output logic [15:0] rdata);
    int n;
    BUS_STYLE_SELECT = mux;
    RW_STROBE_STYLE = rdwr;
    bus_idle;
    HOST_ADDRESS_LINES = a;
    MUXED_ADDR_DATA_LOW_IN = mux ? a : wd[7:0];
    DATA_HIGH_BYTE_IN = wd[15:8];
    ADDRESS_LATCH_STROBE = mux;
    repeat (3) tick;
    ADDRESS_LATCH_STROBE = 1'b0;
    MUXED_ADDR_DATA_LOW_IN = wd[7:0];
    tick;
    CS_N = 1'b0;
    STROBE_OR_READ_IN = (mux && rdwr) ? !rd : mux;
    RW_OR_WR_IN = rd;
    n = 0;
    do begin tick; n++; end while (TRANSFER_ACK_N !== 1'b0 && n < 20);
    chk("ack_low_driven", {TRANSFER_ACK_OE, TRANSFER_ACK_N}, 16'h2);
    chk("data_oe", {MUXED_ADDR_DATA_LOW_OE, DATA_HIGH_BYTE_OE}, rd ? 16'h3 : 16'h0);
    rdata = {DATA_HIGH_BYTE_OUT, MUXED_ADDR_DATA_LOW_OUT};
    tick;
    chk("ack_stands", TRANSFER_ACK_N, 16'h0);
    bus_idle;
    n = 0;
    do begin tick; n++; end while (TRANSFER_ACK_N !== 1'b1 && n < 20);
    chk("ack_high_driven", {TRANSFER_ACK_OE, TRANSFER_ACK_N}, 16'h3);
    tick;
    chk("ack_released", TRANSFER_ACK_OE, 16'h0);
    chk("data_released", {MUXED_ADDR_DATA_LOW_OE, DATA_HIGH_BYTE_OE}, 16'h0);
  endtask

  task automatic sc_reset;
    SRST = 1'b1;
    repeat (19) tick;
    chk("rst_oe", {SERIAL_OUT_OE, MUXED_ADDR_DATA_LOW_OE, DATA_HIGH_BYTE_OE, TRANSFER_ACK_OE},
      16'h0);
    chk("rst_ack", TRANSFER_ACK_N, 16'h1);
    tick;
    SRST = 1'b0;
    tick;
  endtask

  // Second write must not disturb the first address
  task automatic sc_nonmux;
    host(1'b0, 1'b0, 1'b0, 8'h23, 16'h0145, r);
    host(1'b0, 1'b0, 1'b0, 8'h24, 16'h0012, r);
    host(1'b0, 1'b0, 1'b1, 8'h23, 16'h0000, r);
    chk("nonmux_rd23", r, 16'h0145);
    host(1'b0, 1'b0, 1'b1, 8'h24, 16'h0000, r);
    chk("nonmux_rd24", r, 16'h0012);
  endtask

  task automatic sc_cs_ignored;
    BUS_STYLE_SELECT = 1'b0;
    bus_idle;
    STROBE_OR_READ_IN = 1'b0;
    repeat (12) begin
      tick;
      chk("no_ack_unselected", TRANSFER_ACK_OE, 16'h0);
    end
    bus_idle;
    repeat (4) tick;
  endtask

  task automatic sc_mux_strobe;
    host(1'b1, 1'b0, 1'b0, 8'h24, 16'h0033, r);
    host(1'b1, 1'b0, 1'b1, 8'h24, 16'h0000, r);
    chk("mux_rd24", r, 16'h0033);
    host(1'b1, 1'b0, 1'b1, 8'h23, 16'h0000, r);
    chk("mux_rd23", r, 16'h0145);
  endtask

  // High byte of a separate-strobe write is not stored
  task automatic sc_mux_rdwr;
    host(1'b1, 1'b1, 1'b0, 8'h24, 16'hFF77, r);
    host(1'b1, 1'b1, 1'b1, 8'h24, 16'h0000, r);
    chk("rdwr_rd24", r, 16'h0077);
  endtask

  // Output stream 1 slot 3 carries source stream 2 slot 5
  task automatic sc_serial;
    int n;
    logic [7:0] got;
    // Data memory holds aligned bytes only after a full frame past the first pulse
    repeat (2) @(negedge FRAME_PULSE_IN);
    n = 0;
    do begin tick; n++; end while (SERIAL_OUT_OE[1] !== 1'b0 && n < 15000);
    n = 0;
    do begin tick; n++; end while (SERIAL_OUT_OE[1] !== 1'b1 && n < 15000);
    chk("slot_enabled", SERIAL_OUT_OE[1], 16'h1);
    got = 8'h00;
    #244;
    for (int b = 0; b < 8; b++) begin
      got = {got[6:0], SERIAL_OUT_STREAMS[1]};
      #488;
    end
    chk("switched_byte", got, 16'h00A5);
    chk("slot_floats_after", SERIAL_OUT_OE[1], 16'h0);
    tick;
  endtask

  task automatic sc_pin_reset;
    RESET_N = 1'b0;
    repeat (8) tick;
    chk("pin_rst_oe", {SERIAL_OUT_OE, MUXED_ADDR_DATA_LOW_OE, DATA_HIGH_BYTE_OE, TRANSFER_ACK_OE},
      16'h0);
    chk("pin_rst_out", SERIAL_OUT_STREAMS, 16'h0);
    RESET_N = 1'b1;
    repeat (6) tick;
    host(1'b0, 1'b0, 1'b1, 8'h23, 16'h0000, r);
    chk("enable_cleared", r, 16'h0045);
  endtask

  initial begin
    fail_count = 0;
    tests_run = 0;
    SRST = 1'b1;
    CLK_EN = 1'b1;
    RESET_N = 1'b1;
    BUS_STYLE_SELECT = 1'b0;
    RW_STROBE_STYLE = 1'b0;
    HOST_ADDRESS_LINES = 8'h00;
    MUXED_ADDR_DATA_LOW_IN = 8'h00;
    DATA_HIGH_BYTE_IN = 8'h00;
    bus_idle;
    sc_reset;
    sc_nonmux;
    sc_cs_ignored;
    sc_mux_strobe;
    sc_mux_rdwr;
    sc_serial;
    sc_pin_reset;
    final_report;
  end

  // Three frames of waiting plus host traffic fit well inside this span
  initial begin
    #1500000;
    fail_count++;
    final_report;
  end
endmodule

// >>> bench/tsi_far_model.sv
// Far-end serial source: serial clock, frame pulse and eight input streams
`timescale 1ns/1ps
module tsi_far_model #(
  parameter realtime HALF_NS = 122.07
) (
  output logic SER_CLK,
  output logic FRAME_PULSE_IN,
  output logic [7:0] SERIAL_IN_STREAMS
);
  int k;
  logic [7:0] b;

  // Only one source slot carries the marker byte, so a wrong route shows
  function automatic logic [7:0] chan_byte(input int s, input int c);
    return (s == 2 && c == 5) ? 8'hA5 : 8'h3C;
  endfunction

  initial begin
    SER_CLK = 1'b0;
    FRAME_PULSE_IN = 1'b1;
    SERIAL_IN_STREAMS = 8'h00;
    k = 0;
    forever begin
      #HALF_NS SER_CLK = 1'b1;
      // 512 clocks per frame, pulse across the boundary
      FRAME_PULSE_IN = (k == 511) ? 1'b0 : 1'b1;
      #HALF_NS SER_CLK = 1'b0;
      k = (k + 1) % 512;
      // bits MSB first, two clocks each
      for (int s = 0; s < 8; s++) begin
        b = chan_byte(s, k / 16);
        SERIAL_IN_STREAMS[s] = b[7 - ((k / 2) % 8)];
      end
    end
  end
endmodule

// >>> core/tsi_switch.sv
// Stream switch core: serial framing, data path FIFO, memories and host port
`timescale 1ns/1ps
`include "tsi_map.svh"

module tsi_fifo #(
  parameter int WIDTH = 69,
  parameter int DEPTH = `TSI_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r < (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Fill level never passes depth
  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

module tsi_switch (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  input wire logic SER_CLK,
  input wire logic FRAME_PULSE_IN,
  input wire logic [7:0] SERIAL_IN_STREAMS,
  output logic [7:0] SERIAL_OUT_STREAMS,
  output logic [7:0] SERIAL_OUT_OE,
  input wire logic RESET_N,
  input wire logic CS_N,
  input wire logic STROBE_OR_READ_IN,
  input wire logic RW_OR_WR_IN,
  input wire logic ADDRESS_LATCH_STROBE,
  input wire logic BUS_STYLE_SELECT,
  input wire logic RW_STROBE_STYLE,
  input wire logic [7:0] HOST_ADDRESS_LINES,
  input wire logic [7:0] MUXED_ADDR_DATA_LOW_IN,
  output logic [7:0] MUXED_ADDR_DATA_LOW_OUT,
  output logic MUXED_ADDR_DATA_LOW_OE,
  input wire logic [7:0] DATA_HIGH_BYTE_IN,
  output logic [7:0] DATA_HIGH_BYTE_OUT,
  output logic DATA_HIGH_BYTE_OE,
  output logic TRANSFER_ACK_N,
  output logic TRANSFER_ACK_OE
);
  localparam int NS = `TSI_STREAMS;
  localparam int FW = $bits(tsi_pkg::tsi_rx_word_s);
  localparam logic [9:0] FRAME_CLKS = 10'(`TSI_FRAME_CLKS);
  localparam logic [2:0] RST_MIN_CYC = 3'(`TSI_RST_MIN_CYC);
  // Chain restarts on an idle, deselected bus so no false access follows reset
  localparam tsi_pkg::tsi_pins_s PINS_IDLE = '{cs_n: `TSI_PIN_INACT,
    reset_n: `TSI_PIN_INACT, frame_pulse_in: `TSI_FP_IDLE_RST, default: '0};

  tsi_pkg::tsi_pins_s pins;
  tsi_pkg::tsi_pins_s s1_r;
  tsi_pkg::tsi_pins_s s2_r;
  logic rst;
  logic dev_rst_r;
  logic [2:0] rst_cnt_r;

  assign pins = '{SER_CLK, FRAME_PULSE_IN, SERIAL_IN_STREAMS, RESET_N, CS_N,
                  STROBE_OR_READ_IN, RW_OR_WR_IN, ADDRESS_LATCH_STROBE,
                  BUS_STYLE_SELECT, RW_STROBE_STYLE, HOST_ADDRESS_LINES,
                  MUXED_ADDR_DATA_LOW_IN, DATA_HIGH_BYTE_IN};

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      s1_r <= PINS_IDLE;
      s2_r <= PINS_IDLE;
    end else if (CLK_EN) begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rst_cnt_r <= '0;
      dev_rst_r <= 1'b0;
    end else if (CLK_EN) begin
      if (s2_r.reset_n) begin
        rst_cnt_r <= '0;
        dev_rst_r <= 1'b0;
      end else if (rst_cnt_r < RST_MIN_CYC - 3'h1) begin
        rst_cnt_r <= rst_cnt_r + 3'h1;
      end else begin
        dev_rst_r <= 1'b1;
      end
    end
  end
  assign rst = SRST || dev_rst_r;

  // Serial clock edges and frame pulse polarity
  logic ser_q_r;
  logic ser_fall;
  logic ser_rise;
  logic fp_q_r;
  logic fp_idle_r;
  logic [4:0] fp_run_r;
  logic fp_act;
  logic fp_seen_r;
  logic [9:0] clk_cnt_r;
  logic [4:0] cur_ch;
  logic [2:0] cur_bit;

  assign ser_fall = ser_q_r && !s2_r.ser_clk;
  assign ser_rise = !ser_q_r && s2_r.ser_clk;
  assign fp_act = (s2_r.frame_pulse_in != fp_idle_r);
  assign cur_ch = clk_cnt_r[8:4];
  assign cur_bit = clk_cnt_r[3:1];

  // Long-held level is idle, pulse is the other
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      ser_q_r <= 1'b0;
      fp_q_r <= `TSI_FP_IDLE_RST;
      fp_idle_r <= `TSI_FP_IDLE_RST;
      fp_run_r <= '0;
    end else if (CLK_EN) begin
      ser_q_r <= s2_r.ser_clk;
      if (ser_fall) begin
        fp_q_r <= s2_r.frame_pulse_in;
        if (s2_r.frame_pulse_in != fp_q_r) begin
          fp_run_r <= '0;
        end else if (fp_run_r != `TSI_FP_IDLE_MIN) begin
          fp_run_r <= fp_run_r + 5'h01;
        end else begin
          fp_idle_r <= s2_r.frame_pulse_in;
        end
      end
    end
  end

  // Frame counter in serial clocks, restarted by the pulse
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      clk_cnt_r <= '0;
      fp_seen_r <= 1'b0;
    end else if (CLK_EN && ser_fall) begin
      fp_seen_r <= fp_act;
      if (fp_act && !fp_seen_r) begin
        clk_cnt_r <= '0;
      end else if (clk_cnt_r == FRAME_CLKS - 10'h001) begin
        clk_cnt_r <= '0;
      end else begin
        clk_cnt_r <= clk_cnt_r + 10'h001;
      end
    end
  end

  // Receive: sample on the rising serial edge in the second clock of each bit
  logic [7:0] rx_sh_r [NS];
  logic [63:0] rx_bytes;
  logic rx_sample;
  logic rx_push_r;
  tsi_pkg::tsi_rx_word_s rx_word_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  tsi_pkg::tsi_rx_word_s fifo_out;

  assign rx_sample = ser_rise && clk_cnt_r[0];

  genvar gk;
  generate
    for (gk = 0; gk < NS; gk++) begin : g_rx
      assign rx_bytes[gk*8 +: 8] = {rx_sh_r[gk][6:0], s2_r.serial_in_streams[gk]};
      always_ff @(posedge REF_CLK) begin
        if (rst) begin
          rx_sh_r[gk] <= '0;
        end else if (CLK_EN && rx_sample) begin
          rx_sh_r[gk] <= rx_bytes[gk*8 +: 8];
        end
      end
    end
  endgenerate

  // Push one word per channel; a full buffer holds it until space frees or the next channel's word overwrites it
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      rx_push_r <= 1'b0;
      rx_word_r <= '0;
    end else if (CLK_EN) begin
      if (rx_sample && cur_bit == `TSI_BIT_LAST) begin
        rx_push_r <= 1'b1;
        rx_word_r <= '{cur_ch, rx_bytes};
      end else if (fifo_in_ready) begin
        rx_push_r <= 1'b0;
      end
    end
  end

  tsi_fifo #(.WIDTH(FW), .DEPTH(`TSI_FIFO_DEPTH)) u_fifo (
    .clk(REF_CLK),
    .ce(CLK_EN),
    .rst(rst),
    .in_valid(rx_push_r),
    .in_ready(fifo_in_ready),
    .in_data(rx_word_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // Data memory: one row per channel, all streams side by side
  logic [63:0] dmem [`TSI_CHANNELS];
  logic [7:0] cmem_src [256];
  logic [255:0] cmem_oe_r;
  logic fetch_busy_r;
  logic fetch_ph_r;
  logic [2:0] fetch_k_r;
  logic [7:0] fsrc_r;
  logic foe_r;
  logic [7:0] tx_hold_r [NS];
  logic [NS-1:0] hold_oe_r;
  logic slot_start;
  logic [4:0] next_ch;

  // Single read port: the output fetch stalls the buffer drain
  assign fifo_out_ready = !fetch_busy_r;
  assign slot_start = ser_fall && !clk_cnt_r[0] && clk_cnt_r[3:0] == `TSI_SLOT_START;
  assign next_ch = cur_ch + 5'h01;

  always_ff @(posedge REF_CLK) begin
    if (CLK_EN && fifo_out_valid && fifo_out_ready) begin
      dmem[fifo_out.channel] <= fifo_out.bytes;
    end
  end

  // Fetch next slot's byte per stream through the connection memory
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      fetch_busy_r <= 1'b0;
      fetch_ph_r <= 1'b0;
      fetch_k_r <= '0;
      fsrc_r <= '0;
      foe_r <= 1'b0;
      hold_oe_r <= '0;
      for (int i = 0; i < NS; i++) begin
        tx_hold_r[i] <= '0;
      end
    end else if (CLK_EN) begin
      if (slot_start) begin
        fetch_busy_r <= 1'b1;
        fetch_ph_r <= 1'b0;
        fetch_k_r <= '0;
      end else if (fetch_busy_r && !fetch_ph_r) begin
        fsrc_r <= cmem_src[{fetch_k_r, next_ch}];
        foe_r <= cmem_oe_r[{fetch_k_r, next_ch}];
        fetch_ph_r <= 1'b1;
      end else if (fetch_busy_r) begin
        tx_hold_r[fetch_k_r] <= dmem[fsrc_r[4:0]][fsrc_r[7:5]*8 +: 8];
        hold_oe_r[fetch_k_r] <= foe_r;
        fetch_ph_r <= 1'b0;
        fetch_k_r <= fetch_k_r + 3'h1;
        fetch_busy_r <= (fetch_k_r != `TSI_K_LAST);
      end
    end
  end

  // Transmit: load at slot start, shift on each bit boundary
  logic [7:0] tx_sh_r [NS];

  // Outputs float in reset and on disabled channels
  generate
    for (gk = 0; gk < NS; gk++) begin : g_tx
      assign SERIAL_OUT_STREAMS[gk] = tx_sh_r[gk][7];
      always_ff @(posedge REF_CLK) begin
        if (rst) begin
          tx_sh_r[gk] <= '0;
          SERIAL_OUT_OE[gk] <= 1'b0;
        end else if (CLK_EN && slot_start) begin
          tx_sh_r[gk] <= tx_hold_r[gk];
          SERIAL_OUT_OE[gk] <= hold_oe_r[gk];
        end else if (CLK_EN && ser_fall && !clk_cnt_r[0]) begin
          tx_sh_r[gk] <= {tx_sh_r[gk][6:0], 1'b0};
        end
      end
    end
  endgenerate

  // Host port decoding
  function automatic tsi_pkg::tsi_access_s decode_access(input tsi_pkg::tsi_pins_s p);
    tsi_pkg::tsi_access_s a;
    logic act;
    a = '0;
    act = 1'b0;
    if (p.bus_style_select && p.rw_strobe_style) begin
      a.rd = !p.strobe_or_read_in;
      a.wr = !p.rw_or_wr_in;
    end else begin
      act = p.bus_style_select ? p.strobe_or_read_in : !p.strobe_or_read_in;
      a.rd = act && p.rw_or_wr_in;
      a.wr = act && !p.rw_or_wr_in;
    end
    if (p.cs_n) begin
      a = '0;
    end
    return a;
  endfunction

  tsi_pkg::tsi_access_s acc;
  tsi_pkg::tsi_host_e hst_r;
  logic [7:0] lat_addr_r;
  logic [7:0] host_addr;

  assign acc = decode_access(s2_r);
  assign host_addr = s2_r.bus_style_select ? lat_addr_r : s2_r.host_address_lines;

  // Address latched while latch strobe is high
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      lat_addr_r <= '0;
    end else if (CLK_EN && s2_r.address_latch_strobe) begin
      lat_addr_r <= s2_r.muxed_addr_data_low;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (CLK_EN && hst_r == tsi_pkg::TSI_H_IDLE && acc.wr) begin
      cmem_src[host_addr] <= s2_r.muxed_addr_data_low;
    end
  end

  // Low write strobe style takes only the low byte
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      cmem_oe_r <= '0;
    end else if (CLK_EN && hst_r == tsi_pkg::TSI_H_IDLE && acc.wr &&
                 !(s2_r.bus_style_select && s2_r.rw_strobe_style)) begin
      cmem_oe_r[host_addr] <= s2_r.data_high_byte[0];
    end
  end

  // Access, acknowledge low, drive high, release
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      hst_r <= tsi_pkg::TSI_H_IDLE;
      TRANSFER_ACK_N <= `TSI_ACK_IDLE;
      TRANSFER_ACK_OE <= 1'b0;
      MUXED_ADDR_DATA_LOW_OUT <= '0;
      DATA_HIGH_BYTE_OUT <= '0;
      MUXED_ADDR_DATA_LOW_OE <= 1'b0;
      DATA_HIGH_BYTE_OE <= 1'b0;
    end else if (CLK_EN) begin
      unique case (hst_r)
        tsi_pkg::TSI_H_IDLE: begin
          TRANSFER_ACK_OE <= 1'b0;
          if (acc.rd || acc.wr) begin
            hst_r <= tsi_pkg::TSI_H_ACK;
            TRANSFER_ACK_N <= 1'b0;
            TRANSFER_ACK_OE <= 1'b1;
            MUXED_ADDR_DATA_LOW_OUT <= cmem_src[host_addr];
            DATA_HIGH_BYTE_OUT <= {`TSI_HI_PAD, cmem_oe_r[host_addr]};
            MUXED_ADDR_DATA_LOW_OE <= acc.rd;
            DATA_HIGH_BYTE_OE <= acc.rd;
          end
        end
        tsi_pkg::TSI_H_ACK: begin
          if (!(acc.rd || acc.wr)) begin
            hst_r <= tsi_pkg::TSI_H_END;
            TRANSFER_ACK_N <= `TSI_ACK_IDLE;
            MUXED_ADDR_DATA_LOW_OE <= 1'b0;
            DATA_HIGH_BYTE_OE <= 1'b0;
          end
        end
        tsi_pkg::TSI_H_END: begin
          hst_r <= tsi_pkg::TSI_H_IDLE;
          TRANSFER_ACK_OE <= 1'b0;
        end
      endcase
    end
  end

  sequence ack_low_s;
    TRANSFER_ACK_OE && !TRANSFER_ACK_N;
  endsequence
  sequence ack_release_s;
    (TRANSFER_ACK_OE && TRANSFER_ACK_N) ##1 !TRANSFER_ACK_OE;
  endsequence

  reset_float_a: assert property (@(posedge REF_CLK) CLK_EN && rst |=> SERIAL_OUT_OE == '0 &&
    !MUXED_ADDR_DATA_LOW_OE && !DATA_HIGH_BYTE_OE) else $error("outputs not floated in reset");
  ack_sequence_a: assert property (@(posedge REF_CLK) disable iff (rst || !CLK_EN)
    ack_low_s ##1 !(TRANSFER_ACK_OE && !TRANSFER_ACK_N) |-> ack_release_s)
    else $error("acknowledge release wrong");
  cs_gate_a: assert property (@(posedge REF_CLK) disable iff (rst || !CLK_EN)
    hst_r == tsi_pkg::TSI_H_IDLE && s2_r.cs_n |=> !TRANSFER_ACK_OE) else $error("answer without select");
  read_drive_a: assert property (@(posedge REF_CLK) disable iff (rst || !CLK_EN)
    hst_r == tsi_pkg::TSI_H_IDLE && acc.rd |=> MUXED_ADDR_DATA_LOW_OE && DATA_HIGH_BYTE_OE)
    else $error("read did not drive both bytes");
  write_nodrive_a: assert property (@(posedge REF_CLK) disable iff (rst || !CLK_EN)
    hst_r == tsi_pkg::TSI_H_IDLE && acc.wr && !acc.rd |=> !MUXED_ADDR_DATA_LOW_OE)
    else $error("write drove data bus");
  frame_wrap_a: assert property (@(posedge REF_CLK) disable iff (rst || !CLK_EN)
    clk_cnt_r < FRAME_CLKS) else $error("frame counter overrun");
  fp_learn_a: assert property (@(posedge REF_CLK) disable iff (rst || !CLK_EN)
    ser_fall && fp_run_r == `TSI_FP_IDLE_MIN && s2_r.frame_pulse_in == fp_q_r
    |=> fp_idle_r == $past(s2_r.frame_pulse_in)) else $error("idle level not learned");
  fetch_len_a: assert property (@(posedge REF_CLK) disable iff (rst || !CLK_EN)
    $rose(fetch_busy_r) |-> fetch_busy_r [*8]) else $error("fetch ended early");
  reset_filter_a: assert property (@(posedge REF_CLK) disable iff (SRST || !CLK_EN)
    $rose(dev_rst_r) |-> !s2_r.reset_n && !$past(s2_r.reset_n)) else $error("short reset accepted");
endmodule

// >>> shared/tsi_map.svh
// Constant map for the time slot interchange switch
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

`define TSI_STREAMS 8
`define TSI_CHANNELS 32
`define TSI_FIFO_DEPTH 4
`define TSI_REF_PERIOD_NS 20
`define TSI_RST_MIN_NS 100
`define TSI_RST_MIN_CYC ((`TSI_RST_MIN_NS + `TSI_REF_PERIOD_NS - 1) / `TSI_REF_PERIOD_NS)
`define TSI_FRAME_NS 125000
`define TSI_SER_KHZ 4096
`define TSI_FRAME_CLKS ((`TSI_FRAME_NS * `TSI_SER_KHZ) / 1000000)
`define TSI_FP_IDLE_MIN 5'h10
`define TSI_BIT_LAST 3'h7
`define TSI_SLOT_START 4'h0
`define TSI_CH_LAST 5'h1F
`define TSI_K_LAST 3'h7
`define TSI_FP_IDLE_RST 1'b1
`define TSI_PIN_INACT 1'b1
`define TSI_ACK_IDLE 1'b1
`define TSI_HI_PAD 7'h00

`endif

// >>> shared/tsi_pkg.sv
// Types shared by the switch core
package tsi_pkg;
  typedef logic [7:0] tsi_byte_t;

  typedef struct packed {
    logic ser_clk;
    logic frame_pulse_in;
    logic [7:0] serial_in_streams;
    logic reset_n;
    logic cs_n;
    logic strobe_or_read_in;
    logic rw_or_wr_in;
    logic address_latch_strobe;
    logic bus_style_select;
    logic rw_strobe_style;
    logic [7:0] host_address_lines;
    logic [7:0] muxed_addr_data_low;
    logic [7:0] data_high_byte;
  } tsi_pins_s;

  typedef struct packed {
    logic [4:0] channel;
    logic [63:0] bytes;
  } tsi_rx_word_s;

  typedef struct packed {
    logic rd;
    logic wr;
  } tsi_access_s;

  typedef enum logic [1:0] {TSI_H_IDLE, TSI_H_ACK, TSI_H_END} tsi_host_e;
endpackage
